// >>> rtl/rom_pkg.sv
package rom_pkg;

  // ************************************************
  // Sizes
  // ************************************************
  localparam int NUM_RELAYS = 2;
  localparam int NUM_ALARMS = 4;
  localparam int WIDTH_W    = 14;
  localparam int ADDR_W     = 8;
  localparam int LOG_CNT_W  = 16;
  localparam int TICK_W     = 28;

  localparam logic [WIDTH_W-1:0] WIDTH_MAX = 14'h270F;

  // ************************************************
  // Register offsets
  // ************************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_WIDTH0   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_WIDTH1   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SEL0     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SEL1     = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PRIO     = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_DROP_DLY = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_EVT_LOG  = 8'h2C;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_BHV_POS  = 1;
  localparam int CTRL_STRIDE   = 4;
  localparam int CMD_ON_POS    = 0;
  localparam int CMD_OFF_POS   = 1;
  localparam int CMD_STRIDE    = 2;
  localparam int STAT_RELAY_POS = 0;
  localparam int STAT_IO_POS    = 2;
  localparam int STAT_LED_POS   = 3;
  localparam int STAT_ACT_POS   = 4;
  localparam int IRQ_RELAY_POS = 0;
  localparam int IRQ_ALARM_POS = 2;
  localparam int IRQ_HIGH_POS  = 3;
  localparam int IRQ_W         = 4;
  localparam int PRIO_STRIDE   = 2;
  localparam int LOG_IDX_POS   = 0;
  localparam int LOG_PRIO_POS  = 4;
  localparam int LOG_CNT_POS   = 16;

  // ************************************************
  // Reset values
  // ************************************************
  localparam logic [WIDTH_W-1:0]    WIDTH_RST = 14'h0000;
  localparam logic [NUM_ALARMS-1:0] SEL_RST   = 4'h0;
  localparam logic [IRQ_W-1:0]      MASK_RST  = 4'h0;
  localparam logic [WIDTH_W-1:0]    DROP_RST  = 14'h0000;

  // ************************************************
  // Timing
  // ************************************************
  localparam int unsigned TICK_PERIOD_MS  = 1000;
  localparam int unsigned CLK_FREQ_KHZ    = 250000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_MS * CLK_FREQ_KHZ;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic {
    MODE_REMOTE = 1'b0,
    MODE_EVENT  = 1'b1
  } rom_mode_t;

  typedef enum logic [1:0] {
    BHV_LATCH  = 2'b00,
    BHV_PULSE  = 2'b01,
    BHV_RETAIN = 2'b10
  } rom_bhv_t;

  typedef enum logic [1:0] {
    PRIO_LOW  = 2'b00,
    PRIO_MED  = 2'b01,
    PRIO_HIGH = 2'b10
  } rom_prio_t;

  typedef struct packed {
    rom_bhv_t  bhv;
    rom_mode_t mode;
  } rom_relay_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic              valid;
  } rom_aph_t;

endpackage

// >>> rtl/rom_sec_timer.sv
`timescale 1ns/100ps
module rom_sec_timer #(
  parameter int W = 14
) (
  input  wire logic         clk,      // System clock
  input  wire logic         rst_n,    // Synchronous reset
  input  wire logic         tick,     // One-second enable
  input  wire logic         load,     // Reload request
  input  wire logic [W-1:0] load_val, // Seconds to load
  output logic      [W-1:0] count     // Seconds remaining
);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  always_comb begin
    nxt_count = count_ff;
    if (load) begin
      nxt_count = load_val;
    end else if (tick && count_ff != '0) begin
      nxt_count = count_ff - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

endmodule

// >>> rtl/rom_relay_ctrl.sv
// Operation
// - Remote mode: relays switch only by on/off commands from the bus.
// - Event mode: relay goes active when an associated alarm triggers.
// - Remote latched: relay stays closed until an off command arrives.
// - Event latched: relay opens only after associated alarms have dropped out.
// - Pulse: relay stays on for programmed seconds, 0 to 9999, then off.
// - Retentive: set command turns on, clear command alone turns off.
// - Retentive state kept in non-volatile storage and restored at power return.
// - Event mode: any alarm in the relay's selection mask triggers it.
// - Activity LED blinks steadily while the expansion module is attached.
// - Each alarm has high, medium or low priority; generated alarms are logged; of alarms new in one cycle, only the lowest index is logged, count +1.
// - Dropout needs magnitude beyond dropout setpoint for the whole dropout delay.
`timescale 1ns/100ps
module rom_relay_ctrl
  import rom_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic                  clk,           // System clock
  input  wire logic                  rst_n,         // Synchronous reset
  input  wire logic                  hsel,          // AHB select
  input  wire logic [31:0]           haddr,         // AHB address
  input  wire logic [1:0]            htrans,        // AHB transfer type
  input  wire logic                  hwrite,        // AHB write
  input  wire logic [2:0]            hsize,         // AHB size
  input  wire logic [31:0]           hwdata,        // AHB write data
  input  wire logic                  hready,        // AHB bus ready
  output logic      [31:0]           hrdata,        // AHB read data
  output logic                       hreadyout,     // AHB slave ready
  output logic                       hresp,         // AHB response
  input  wire logic [NUM_ALARMS-1:0] alarm_pickup,  // Alarm pickup qualified
  input  wire logic [NUM_ALARMS-1:0] alarm_beyond,  // Magnitude beyond dropout
  input  wire logic                  io_attached,   // Expansion module present
  input  wire logic [NUM_RELAYS-1:0] nv_state_in,   // Retained relay state
  output logic      [NUM_RELAYS-1:0] nv_wr_data,    // Retained state to store
  output logic                       nv_wr_en,      // Store strobe
  output logic      [NUM_RELAYS-1:0] relay_out,     // Relay coil drive
  output logic                       io_led,        // Activity LED
  output logic                       irq            // Interrupt level
);

  // ************************************************
  // Bus slave
  // ************************************************
  rom_aph_t    aph_ff, nxt_aph;
  logic        hready_ff, nxt_hready;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic        accept, rd_do, wr_do;

  assign accept = hsel && htrans[1] && hready;
  // Reads insert one wait state because read data is registered in hrdata_ff
  assign rd_do  = aph_ff.valid && !aph_ff.write;
  assign wr_do  = aph_ff.valid && aph_ff.write;

  // ************************************************
  // Registers
  // ************************************************
  rom_relay_cfg_t [NUM_RELAYS-1:0]              cfg_ff, nxt_cfg;
  logic [NUM_RELAYS-1:0][WIDTH_W-1:0]           width_ff, nxt_width;
  logic [NUM_RELAYS-1:0][NUM_ALARMS-1:0]        sel_ff, nxt_sel;
  logic [NUM_ALARMS-1:0][1:0]                   prio_ff, nxt_prio;
  logic [WIDTH_W-1:0]                           drop_ff, nxt_drop;
  logic [IRQ_W-1:0]                             mask_ff, nxt_mask;
  logic [IRQ_W-1:0]                             stat_ff, nxt_stat;
  logic [1:0]                                   log_idx_ff, nxt_log_idx;
  logic [1:0]                                   log_prio_ff, nxt_log_prio;
  logic [LOG_CNT_W-1:0]                         log_cnt_ff, nxt_log_cnt;
  logic [NUM_RELAYS-1:0]                        cmd_on, cmd_off;
  logic [WIDTH_W-1:0]                           wr_width;

  // Out-of-range widths saturate at the documented maximum
  assign wr_width = (hwdata[31:WIDTH_W] != '0 || hwdata[WIDTH_W-1:0] > WIDTH_MAX) ?
                    WIDTH_MAX : hwdata[WIDTH_W-1:0];

  logic [NUM_ALARMS-1:0]                  act_ff, nxt_act, alarm_new, drop_done;
  logic [NUM_ALARMS-1:0][WIDTH_W-1:0]     drop_cnt;
  logic [NUM_RELAYS-1:0]                  lat_ff, nxt_lat;
  logic [NUM_RELAYS-1:0]                  ret_ff, nxt_ret;
  logic [NUM_RELAYS-1:0]                  relay_ff, nxt_relay;
  logic [NUM_RELAYS-1:0]                  trig, pulse_load;
  logic [NUM_RELAYS-1:0][WIDTH_W-1:0]     pulse_cnt;
  logic                                   restore_ff, nxt_restore;
  logic                                   nv_en_ff, nxt_nv_en;
  logic [NUM_RELAYS-1:0]                  nv_data_ff, nxt_nv_data;
  logic [TICK_W-1:0]                      tick_cnt_ff, nxt_tick_cnt;
  logic                                   tick_ff, nxt_tick;
  logic                                   led_ff, nxt_led;
  logic                                   irq_ff, nxt_irq;

  // ************************************************
  // Timers and next-state logic
  // ************************************************
  for (genvar a = 0; a < NUM_ALARMS; a++) begin : g_drop
    rom_sec_timer #(.W(WIDTH_W)) u_drop (
      .clk      (clk),
      .rst_n    (rst_n),
      .tick     (tick_ff),
      .load     (!act_ff[a] || !alarm_beyond[a]),
      .load_val (drop_ff),
      .count    (drop_cnt[a])
    );
    assign drop_done[a] = act_ff[a] && alarm_beyond[a] && drop_cnt[a] == '0;
  end
  for (genvar r = 0; r < NUM_RELAYS; r++) begin : g_pulse
    rom_sec_timer #(.W(WIDTH_W)) u_pulse (
      .clk      (clk),
      .rst_n    (rst_n),
      .tick     (tick_ff),
      .load     (pulse_load[r]),
      .load_val (width_ff[r]),
      .count    (pulse_cnt[r])
    );
  end

  always_comb begin
    nxt_aph    = accept ? rom_aph_t'{addr: haddr[ADDR_W-1:0], write: hwrite, valid: 1'b1} : '0;
    nxt_hready = !(accept && !hwrite);
    nxt_hrdata = hrdata_ff;
    nxt_cfg    = cfg_ff;
    nxt_width  = width_ff;
    nxt_sel    = sel_ff;
    nxt_prio   = prio_ff;
    nxt_drop   = drop_ff;
    nxt_mask   = mask_ff;
    cmd_on     = '0;
    cmd_off    = '0;
    if (wr_do) begin
      unique case (aph_ff.addr)
        OFF_CTRL: begin
          for (int r = 0; r < NUM_RELAYS; r++) begin
            nxt_cfg[r] = rom_relay_cfg_t'(hwdata[r*CTRL_STRIDE+CTRL_MODE_POS +: 3]);
          end
        end
        OFF_CMD: begin
          for (int r = 0; r < NUM_RELAYS; r++) begin
            cmd_on[r]  = hwdata[r*CMD_STRIDE+CMD_ON_POS];
            cmd_off[r] = hwdata[r*CMD_STRIDE+CMD_OFF_POS];
          end
        end
        OFF_WIDTH0:   nxt_width[0] = wr_width;
        OFF_WIDTH1:   nxt_width[1] = wr_width;
        OFF_SEL0:     nxt_sel[0]   = hwdata[NUM_ALARMS-1:0];
        OFF_SEL1:     nxt_sel[1]   = hwdata[NUM_ALARMS-1:0];
        OFF_IRQ_MASK: nxt_mask     = hwdata[IRQ_W-1:0];
        OFF_PRIO:     nxt_prio     = hwdata[NUM_ALARMS*PRIO_STRIDE-1:0];
        OFF_DROP_DLY: nxt_drop     = wr_width;
        default: ;
      endcase
    end
    if (rd_do) begin
      unique case (aph_ff.addr)
        OFF_CTRL: begin
          nxt_hrdata = '0;
          for (int r = 0; r < NUM_RELAYS; r++) begin
            nxt_hrdata[r*CTRL_STRIDE+CTRL_MODE_POS +: 3] = cfg_ff[r];
          end
        end
        OFF_WIDTH0:   nxt_hrdata = 32'(width_ff[0]);
        OFF_WIDTH1:   nxt_hrdata = 32'(width_ff[1]);
        OFF_SEL0:     nxt_hrdata = 32'(sel_ff[0]);
        OFF_SEL1:     nxt_hrdata = 32'(sel_ff[1]);
        OFF_STATUS: begin
          nxt_hrdata = '0;
          nxt_hrdata[STAT_RELAY_POS +: NUM_RELAYS] = relay_ff;
          nxt_hrdata[STAT_IO_POS]                  = io_attached;
          nxt_hrdata[STAT_LED_POS]                 = led_ff;
          nxt_hrdata[STAT_ACT_POS +: NUM_ALARMS]   = act_ff;
        end
        OFF_IRQ_STAT: nxt_hrdata = 32'(stat_ff);
        OFF_IRQ_MASK: nxt_hrdata = 32'(mask_ff);
        OFF_PRIO:     nxt_hrdata = 32'(prio_ff);
        OFF_DROP_DLY: nxt_hrdata = 32'(drop_ff);
        OFF_EVT_LOG: begin
          nxt_hrdata = '0;
          nxt_hrdata[LOG_IDX_POS +: 2]         = log_idx_ff;
          nxt_hrdata[LOG_PRIO_POS +: 2]        = log_prio_ff;
          nxt_hrdata[LOG_CNT_POS +: LOG_CNT_W] = log_cnt_ff;
        end
        default:      nxt_hrdata = '0;
      endcase
    end
  end

  // Alarm activity, triggers and relay behaviours
  always_comb begin
    nxt_act      = act_ff;
    alarm_new    = '0;
    for (int a = 0; a < NUM_ALARMS; a++) begin
      if (!act_ff[a] && alarm_pickup[a]) begin
        nxt_act[a]   = 1'b1;
        alarm_new[a] = 1'b1;
      end else if (drop_done[a]) begin
        nxt_act[a] = 1'b0;
      end
    end
    nxt_restore = 1'b0;
    nxt_lat     = lat_ff;
    // First cycle after reset reloads the retained state; config is at reset, so no relay shows it yet
    nxt_ret     = restore_ff ? nv_state_in : ret_ff;
    nxt_relay   = relay_ff;
    trig        = '0;
    pulse_load  = '0;
    for (int r = 0; r < NUM_RELAYS; r++) begin
      if (cfg_ff[r].mode == MODE_EVENT) begin
        trig[r] = |(alarm_new & sel_ff[r]);
        if (trig[r]) begin
          nxt_lat[r] = 1'b1;
        end else if (!(|(act_ff & sel_ff[r]))) begin
          nxt_lat[r] = 1'b0;
        end
      end else begin
        trig[r] = cmd_on[r];
        if (cmd_off[r]) begin
          nxt_lat[r] = 1'b0;
        end else if (cmd_on[r]) begin
          nxt_lat[r] = 1'b1;
        end
      end
      // Clear command releases a retained relay in either mode
      if (cmd_off[r]) begin
        nxt_ret[r] = 1'b0;
      end else if (trig[r] && cfg_ff[r].bhv == BHV_RETAIN) begin
        nxt_ret[r] = 1'b1;
      end
      pulse_load[r] = trig[r] && cfg_ff[r].bhv == BHV_PULSE;
      unique case (cfg_ff[r].bhv)
        BHV_LATCH:  nxt_relay[r] = nxt_lat[r];
        BHV_PULSE:  nxt_relay[r] = pulse_load[r] ? (width_ff[r] != '0) :
                                   (pulse_cnt[r] != '0);
        BHV_RETAIN: nxt_relay[r] = nxt_ret[r];
        default:    nxt_relay[r] = 1'b0;
      endcase
    end
    nxt_nv_en   = !restore_ff && (nxt_ret != ret_ff);
    nxt_nv_data = nxt_nv_en ? nxt_ret : nv_data_ff;
  end

  // Tick, LED, event log and interrupt
  always_comb begin
    nxt_tick     = 1'b0;
    nxt_tick_cnt = tick_cnt_ff + TICK_W'(1);
    if (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1)) begin
      nxt_tick_cnt = '0;
      nxt_tick     = 1'b1;
    end
    nxt_led = io_attached ? (led_ff ^ tick_ff) : 1'b0;
    nxt_log_idx  = log_idx_ff;
    nxt_log_prio = log_prio_ff;
    nxt_log_cnt  = log_cnt_ff;
    for (int a = NUM_ALARMS - 1; a >= 0; a--) begin
      if (alarm_new[a]) begin
        nxt_log_idx  = 2'(a);
        nxt_log_prio = prio_ff[a];
      end
    end
    if (|alarm_new) begin
      nxt_log_cnt = log_cnt_ff + LOG_CNT_W'(1);
    end
    nxt_stat = stat_ff;
    if (rd_do && aph_ff.addr == OFF_IRQ_STAT) begin
      nxt_stat = '0;
    end
    // Set wins over the read clear
    nxt_stat[IRQ_RELAY_POS +: NUM_RELAYS] |= nxt_relay ^ relay_ff;
    nxt_stat[IRQ_ALARM_POS] |= |alarm_new;
    for (int a = 0; a < NUM_ALARMS; a++) begin
      nxt_stat[IRQ_HIGH_POS] |= alarm_new[a] && prio_ff[a] == PRIO_HIGH;
    end
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  // ************************************************
  // Flip-flops
  // ************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aph_ff      <= '0;
      hready_ff   <= 1'b1;
      hrdata_ff   <= '0;
      cfg_ff      <= '0;
      width_ff    <= {NUM_RELAYS{WIDTH_RST}};
      sel_ff      <= {NUM_RELAYS{SEL_RST}};
      prio_ff     <= '0;
      drop_ff     <= DROP_RST;
      mask_ff     <= MASK_RST;
      stat_ff     <= '0;
      log_idx_ff  <= '0;
      log_prio_ff <= '0;
      log_cnt_ff  <= '0;
      act_ff      <= '0;
      lat_ff      <= '0;
      ret_ff      <= '0;
      relay_ff    <= '0;
      restore_ff  <= 1'b1;
      nv_en_ff    <= 1'b0;
      nv_data_ff  <= '0;
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
      led_ff      <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      aph_ff      <= nxt_aph;
      hready_ff   <= nxt_hready;
      hrdata_ff   <= nxt_hrdata;
      cfg_ff      <= nxt_cfg;
      width_ff    <= nxt_width;
      sel_ff      <= nxt_sel;
      prio_ff     <= nxt_prio;
      drop_ff     <= nxt_drop;
      mask_ff     <= nxt_mask;
      stat_ff     <= nxt_stat;
      log_idx_ff  <= nxt_log_idx;
      log_prio_ff <= nxt_log_prio;
      log_cnt_ff  <= nxt_log_cnt;
      act_ff      <= nxt_act;
      lat_ff      <= nxt_lat;
      ret_ff      <= nxt_ret;
      relay_ff    <= nxt_relay;
      restore_ff  <= nxt_restore;
      nv_en_ff    <= nxt_nv_en;
      nv_data_ff  <= nxt_nv_data;
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
      led_ff      <= nxt_led;
      irq_ff      <= nxt_irq;
    end
  end

  assign hrdata     = hrdata_ff;
  assign hreadyout  = hready_ff;
  assign hresp      = 1'b0;
  assign relay_out  = relay_ff;
  assign io_led     = led_ff;
  assign irq        = irq_ff;
  assign nv_wr_en   = nv_en_ff;
  assign nv_wr_data = nv_data_ff;

endmodule

// >>> testbench/rom_relay_ctrl_properties.sv
`timescale 1ns/100ps
module rom_relay_ctrl_properties
  import rom_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic                  clk,         // Clock
  input wire logic                  rst_n,       // Reset
  input wire logic                  hsel,        // Select
  input wire logic [1:0]            htrans,      // Transfer
  input wire logic                  hwrite,      // Write
  input wire logic                  hready,      // Bus ready
  input wire logic [31:0]           hrdata,      // Read data
  input wire logic                  hreadyout,   // Slave ready
  input wire logic                  hresp,       // Response
  input wire logic                  io_attached, // Module in
  input wire logic                  nv_wr_en,    // Store
  input wire logic [NUM_RELAYS-1:0] relay_out,   // Relays
  input wire logic                  io_led,      // LED
  input wire logic                  irq          // Interrupt
);
  // ****
  // Bus and outputs
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = hsel && htrans[1] && hready;
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  write_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_short_a: assert property (!hreadyout |=> hreadyout)
    else $error("long stall");
  rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved");
  reset_quiet_a: assert property ($rose(rst_n) |-> hreadyout && !irq && relay_out == '0 && !nv_wr_en && !io_led)
    else $error("outputs not at reset value");
  store_pulse_a: assert property (nv_wr_en |=> !nv_wr_en)
    else $error("store strobe long");
  led_dark_a: assert property (!io_attached |=> !io_led)
    else $error("led lit while detached");
  // Assumes a tick period of at least 7 cycles; simulation uses 8
  led_steady_a: assert property ($rose(io_led) ##0 io_attached[*7] |-> io_led)
    else $error("led blinks too fast");
endmodule
bind rom_relay_ctrl rom_relay_ctrl_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
  .clk         (clk),
  .rst_n       (rst_n),
  .hsel        (hsel),
  .htrans      (htrans),
  .hwrite      (hwrite),
  .hready      (hready),
  .hrdata      (hrdata),
  .hreadyout   (hreadyout),
  .hresp       (hresp),
  .io_attached (io_attached),
  .nv_wr_en    (nv_wr_en),
  .relay_out   (relay_out),
  .io_led      (io_led),
  .irq         (irq)
);

// >>> testbench/rom_nv_store.sv
`timescale 1ns/100ps
module rom_nv_store
  import rom_pkg::*;
(
  input  wire logic                  clk,        // Clock
  input  wire logic                  nv_wr_en,   // Store strobe
  input  wire logic [NUM_RELAYS-1:0] nv_wr_data, // State to keep
  output logic      [NUM_RELAYS-1:0] nv_state_in // Kept state
);
  // ****
  // Store has no reset: it outlives power loss
  // ****
  initial nv_state_in = '0;
  always @(posedge clk) begin
    if (nv_wr_en) begin
      nv_state_in <= nv_wr_data;
    end
  end
endmodule

// >>> testbench/rom_relay_ctrl_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; $display("Error %0t: mismatch", $time); end end
module rom_relay_ctrl_bench
  import rom_pkg::*;
;
  logic                  clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, io_attached = 1'b0;
  logic [1:0]            htrans = 2'h0;
  logic [2:0]            hsize = 3'h2;
  logic [31:0]           haddr = '0, hwdata = '0, hrdata, qd;
  logic                  hready, hreadyout, hresp, nv_wr_en, io_led, irq;
  logic [NUM_ALARMS-1:0] alarm_pickup = '0, alarm_beyond = '0;
  logic [NUM_RELAYS-1:0] nv_state_in, nv_wr_data, relay_out;
  int                    failures = 0, n_compared = 0;
  assign hready = hreadyout;
  always #2 clk = ~clk;
  rom_relay_ctrl #(.TICK_CYCLES(8)) rom_relay_ctrl_inst (
    .clk          (clk),
    .rst_n        (rst_n),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .alarm_pickup (alarm_pickup),
    .alarm_beyond (alarm_beyond),
    .io_attached  (io_attached),
    .nv_state_in  (nv_state_in),
    .nv_wr_data   (nv_wr_data),
    .nv_wr_en     (nv_wr_en),
    .relay_out    (relay_out),
    .io_led       (io_led),
    .irq          (irq)
  );
  rom_nv_store rom_nv_store_inst (.clk(clk), .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data), .nv_state_in(nv_state_in));
  // ****
  // Bus tasks
  // ****
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("Error %0t: bus hang", $time);
      end_of_test();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, qd);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_remote;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CMD, 32'h1);
    cyc(2);
    `CHK(relay_out, 2'h1)
    alarm_pickup[0] <= 1'b1;
    cyc(8);
    `CHK(relay_out, 2'h1)
    wr(OFF_CMD, 32'h2);
    cyc(2);
    `CHK(relay_out, 2'h0)
    wr(8'h40, 32'hFFFF);
    bus(8'h40, 1'b0, 32'h0, qd);
    `CHK(qd, 32'h0)
    // Behaviour code 3 keeps the relay open whatever is commanded
    wr(OFF_CTRL, 32'h6);
    wr(OFF_CMD, 32'h1);
    cyc(2);
    `CHK(relay_out[0], 1'b0)
    wr(OFF_CMD, 32'h2);
  endtask
  task automatic t_event;
    wr(OFF_SEL1, 32'h4);
    wr(OFF_DROP_DLY, 32'h2);
    wr(OFF_CTRL, 32'h10);
    alarm_pickup[3] <= 1'b1;
    cyc(4);
    `CHK(relay_out[1], 1'b0)
    alarm_pickup[2] <= 1'b1;
    cyc(3);
    `CHK(relay_out[1], 1'b1)
    alarm_pickup[2] <= 1'b0;
    alarm_beyond[2] <= 1'b1;
    cyc(4);
    `CHK(relay_out[1], 1'b1)
    cyc(30);
    `CHK(relay_out[1], 1'b0)
  endtask
  task automatic t_pulse;
    int n;
    wr(OFF_WIDTH0, 32'h3);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_CMD, 32'h1);
    cyc(2);
    n = 0;
    while (relay_out[0] === 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    // Tick is free running, so the on-time spans width-1 to width seconds
    `CHK(n >= 15 && n <= 25, 1'b1)
    wr(OFF_WIDTH0, 32'h0);
    wr(OFF_CMD, 32'h1);
    cyc(2);
    `CHK(relay_out[0], 1'b0)
    wr(OFF_WIDTH0, 32'h3FFF);
    bus(OFF_WIDTH0, 1'b0, 32'h0, qd);
    `CHK(qd, 32'h0000270F)
  endtask
  task automatic t_led;
    int   n;
    logic last;
    io_attached <= 1'b1;
    cyc(2);
    n = 0;
    repeat (40) begin
      last = io_led;
      cyc(1);
      if (io_led !== last) n++;
    end
    `CHK(n >= 4 && n <= 5, 1'b1)
    io_attached <= 1'b0;
    cyc(2);
    `CHK(io_led, 1'b0)
  endtask
  task automatic t_irq;
    bus(OFF_IRQ_STAT, 1'b0, 32'h0, qd);
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_PRIO, 32'h8);
    alarm_pickup[1] <= 1'b1;
    cyc(4);
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_MASK, 32'hC);
    cyc(3);
    `CHK(irq, 1'b1)
    bus(OFF_IRQ_STAT, 1'b0, 32'h0, qd);
    `CHK(qd[3:2], 2'h3)
    cyc(3);
    `CHK(irq, 1'b0)
    bus(OFF_EVT_LOG, 1'b0, 32'h0, qd);
    `CHK({qd[31:16], qd[5:4], qd[1:0]}, {16'h0004, 2'h2, 2'h1})
  endtask
  task automatic t_retain;
    wr(OFF_CTRL, 32'h4);
    wr(OFF_CMD, 32'h1);
    cyc(3);
    `CHK({relay_out[0], nv_wr_data[0]}, 2'h3)
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    wr(OFF_CTRL, 32'h4);
    cyc(2);
    `CHK(relay_out[0], 1'b1)
    wr(OFF_CMD, 32'h2);
    cyc(2);
    `CHK(relay_out[0], 1'b0)
  endtask
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    t_remote();
    t_event();
    t_pulse();
    t_led();
    t_irq();
    t_retain();
    end_of_test();
  end
endmodule
